// ===== design/keypad_check_pkg.sv
/*
 keypad_check_pkg: constants shared by the key-sequence checker.
 assumes: included before the checker; 32-bit classic wishbone register bus.
*/
package keypad_check_pkg;
   // ---------------------------------------------------------------
   // key codes presented on the key port
   // ---------------------------------------------------------------
   localparam logic [4:0] KEY_CH1 = 5'h00;
   localparam logic [4:0] KEY_CH4 = 5'h03;
   localparam logic [4:0] KEY_NOT = 5'h04;
   localparam logic [4:0] KEY_EDGE = 5'h05;
   localparam logic [4:0] KEY_AND = 5'h06;
   localparam logic [4:0] KEY_OR = 5'h07;
   localparam logic [4:0] KEY_CHANNEL_PROGRAMMING_MODE = 5'h08;
   localparam logic [4:0] KEY_TRIGGER_PROGRAMMING_MODE = 5'h09;
   localparam logic [4:0] KEY_SYNC = 5'h0A;
   localparam logic [4:0] KEY_SLOPE = 5'h0B;
   localparam logic [4:0] KEY_THRESHOLD_ENTRY_KEY = 5'h0C;
   localparam logic [4:0] KEY_LEVEL_UP = 5'h0D;
   localparam logic [4:0] KEY_LEVEL_DN = 5'h0E;
   localparam logic [4:0] KEY_PROBE = 5'h0F;
   localparam logic [4:0] KEY_CLEAR = 5'h10;
   localparam logic [4:0] KEY_A_THEN_B = 5'h11;
   localparam logic [4:0] KEY_SEL_A = 5'h12;
   localparam logic [4:0] KEY_SEL_B = 5'h13;
   localparam logic [4:0] KEY_SCALE_UP = 5'h14;
   localparam logic [4:0] KEY_SCALE_DN = 5'h15;
   localparam logic [4:0] KEY_CH_GAIN = 5'h16;
   // ---------------------------------------------------------------
   // operator error codes
   // ---------------------------------------------------------------
   localparam logic [3:0] ERR_NONE = 4'h0;
   localparam logic [3:0] ERR_OVERLOAD = 4'h1;
   localparam logic [3:0] ERR_PROBE_BUSY = 4'h2;
   localparam logic [3:0] ERR_NEED_CHAN = 4'h3;
   localparam logic [3:0] ERR_NEED_TRIG = 4'h4;
   localparam logic [3:0] ERR_OP_EXPECTED = 4'h5;
   localparam logic [3:0] ERR_INPUT_EXPECTED = 4'h6;
   localparam logic [3:0] ERR_SECOND_OR = 4'h7;
   localparam logic [3:0] ERR_SYNC_CONFLICT = 4'h8;
   localparam logic [3:0] ERR_SYNC_REQUIRED = 4'h9;
   localparam logic [3:0] ERR_EDGE_CONFLICT = 4'hA;
   localparam logic [3:0] ERR_LEVEL_REQUIRED = 4'hB;
   localparam logic [3:0] ERR_NO_FUNC_A = 4'hC;
   localparam logic [3:0] ERR_SECOND_FUNCTION_MISSING_ERROR = 4'hD;
   // ---------------------------------------------------------------
   // register byte offsets
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_STATUS = 4'h0;
   localparam logic [3:0] REG_IRQ_STAT = 4'h4;
   localparam logic [3:0] REG_IRQ_MASK = 4'h8;
   localparam logic [3:0] REG_CONFIG = 4'hC;
   // interrupt status bits
   localparam int IRQ_ERROR = 0;
   localparam int IRQ_BEEP = 1;
   localparam int IRQ_OVERLOAD = 2;
   localparam logic [2:0] IRQ_RESET = 3'h0;
   localparam logic CFG_BEEP_RESET = 1'b1;
   // beep length in ns and clock period in ns
   localparam int BEEP_NS = 1000;
   localparam int CLK_NS = 5;
   localparam int BEEP_CYCLES = BEEP_NS / CLK_NS;
endpackage

// ===== design/trigger_keypad_error_checker.sv
/*
 trigger_keypad_error_checker: checks front-panel keys against the trigger
 programming state and raises numbered operator errors and warning beeps.
 assumes: one key press is a one-cycle pulse on key_valid_i; the scale and
 threshold limit flags come from the owners of those settings; registers
 are reached by a classic wishbone master.
*/
`timescale 1ns/1ps
`default_nettype none
module trigger_keypad_error_checker
   import keypad_check_pkg::*;
#(
   parameter int BEEP_LEN = BEEP_CYCLES
) (
   // clock, reset, enable
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   // keypad
   input wire logic key_valid_i,
   input wire logic [4:0] key_code_i,
   // analog status
   input wire logic overload_i,
   input wire logic grounded_i,
   input wire logic scale_limit_i,
   input wire logic level_limit_i,
   // probe acquisition done from the analog side
   input wire logic probe_done_i,
   // wishbone
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // indicators
   output logic [3:0] error_code_o,
   output logic channel_programming_mode_o,
   output logic trigger_programming_mode_o,
   output logic external_sync_mode_o,
   output logic threshold_entry_key_o,
   output logic sequential_mode_o,
   output logic beep_o,
   output logic irq_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      PR_OFF = 3'b001, // probe offset off
      PR_ACQ = 3'b010, // acquisition running
      PR_HELD = 3'b100 // value locked in
   } probe_t;
   probe_t probe;
   logic [3:0] err; // displayed error code
   logic chan_mode; // channel programming mode lit
   logic trig_mode; // trigger programming mode lit
   logic sync_on; // external sync mode
   logic threshold_entry_key_lit; // threshold key lit
   logic seq_on; // a-then-b mode
   logic sel_b; // function being edited: 0 a, 1 b
   logic [1:0] prog; // function has an input term
   logic [1:0] has_edge; // function holds an edge channel
   logic [1:0] has_or; // function already used its or
   logic [1:0] want_op; // next key must be an operator
   logic [1:0] edge_last; // current term already edge qualified
   logic beep_en; // configuration: beep allowed
   logic [2:0] irq_stat; // sticky events
   logic [2:0] irq_mask; // interrupt enables
   logic [15:0] beep_cnt; // beep time left
   logic over_seen; // overload latched
   // decoded key classes
   function automatic logic is_input(input logic [4:0] k);
      return (k <= KEY_CH4);
   endfunction
   function automatic logic is_trig_key(input logic [4:0] k);
      return is_input(k) || k == KEY_NOT || k == KEY_EDGE || k == KEY_AND ||
             k == KEY_OR || k == KEY_CLEAR;
   endfunction
   // ---------------------------------------------------------------
   // key check: find the error a key would raise
   // ---------------------------------------------------------------
   logic [3:0] next_err;
   logic fs; // selected function index
   always_comb begin
      fs = sel_b;
      next_err = ERR_NONE;
      if (over_seen) begin
         next_err = ERR_OVERLOAD;
      end else if (probe == PR_ACQ && key_code_i != KEY_PROBE) begin
         next_err = ERR_PROBE_BUSY;
      end else if (key_code_i == KEY_CH_GAIN && !chan_mode) begin
         next_err = ERR_NEED_CHAN;
      end else if (is_trig_key(key_code_i) && !trig_mode) begin
         next_err = ERR_NEED_TRIG;
      end else if (((is_input(key_code_i) || key_code_i == KEY_NOT) && want_op[fs]) ||
                   (key_code_i == KEY_EDGE && want_op[fs] && edge_last[fs])) begin
         // an edge may follow its channel once; after that an operator is due
         next_err = ERR_OP_EXPECTED;
      end else if ((key_code_i == KEY_AND || key_code_i == KEY_OR) &&
                   !want_op[fs]) begin
         next_err = ERR_INPUT_EXPECTED;
      end else if (key_code_i == KEY_OR && has_or[fs]) begin
         next_err = ERR_SECOND_OR;
      end else if (key_code_i == KEY_EDGE && sync_on) begin
         next_err = ERR_SYNC_CONFLICT;
      end else if (key_code_i == KEY_SLOPE && !sync_on) begin
         next_err = ERR_SYNC_REQUIRED;
      end else if (key_code_i == KEY_SYNC && !sync_on && |has_edge) begin
         next_err = ERR_EDGE_CONFLICT;
      end else if ((key_code_i == KEY_LEVEL_UP || key_code_i == KEY_LEVEL_DN ||
                    key_code_i == KEY_PROBE) && !threshold_entry_key_lit) begin
         next_err = ERR_LEVEL_REQUIRED;
      end else if (key_code_i == KEY_A_THEN_B && !seq_on && !prog[0]) begin
         next_err = ERR_NO_FUNC_A;
      end else if (key_code_i == KEY_A_THEN_B && !seq_on && !prog[1]) begin
         next_err = ERR_SECOND_FUNCTION_MISSING_ERROR;
      end else if (key_code_i == KEY_CLEAR && seq_on) begin
         // clearing either half is refused while the sequence is on
         next_err = fs ? ERR_SECOND_FUNCTION_MISSING_ERROR : ERR_NO_FUNC_A;
      end
   end
   logic accept; // key taken and acted on
   assign accept = ce_i && key_valid_i && next_err == ERR_NONE;
   // ---------------------------------------------------------------
   // overload latch: held until overvoltage gone and inputs ungrounded
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         over_seen <= 1'b0;
      end else if (ce_i) begin
         if (overload_i) begin
            over_seen <= 1'b1;
         end else if (!grounded_i) begin
            over_seen <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // displayed code: set by rejected key, cleared by accepted key
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         err <= ERR_NONE;
      end else if (ce_i) begin
         if (over_seen) begin
            err <= ERR_OVERLOAD;
         end else if (key_valid_i) begin
            err <= next_err;
         end else if (err == ERR_OVERLOAD) begin
            err <= ERR_NONE;
         end
      end
   end
   // ---------------------------------------------------------------
   // modes: only accepted keys change them
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         chan_mode <= 1'b0;
         trig_mode <= 1'b0;
         sync_on <= 1'b0;
         threshold_entry_key_lit <= 1'b0;
         seq_on <= 1'b0;
         sel_b <= 1'b0;
      end else if (accept) begin
         case (key_code_i)
            KEY_CHANNEL_PROGRAMMING_MODE: begin
               chan_mode <= 1'b1;
               trig_mode <= 1'b0;
            end
            KEY_TRIGGER_PROGRAMMING_MODE: begin
               trig_mode <= 1'b1;
               chan_mode <= 1'b0;
            end
            KEY_SYNC: sync_on <= !sync_on;
            KEY_THRESHOLD_ENTRY_KEY: threshold_entry_key_lit <= !threshold_entry_key_lit;
            KEY_A_THEN_B: seq_on <= !seq_on;
            KEY_SEL_A: sel_b <= 1'b0;
            KEY_SEL_B: sel_b <= 1'b1;
            default: begin
               // other keys leave the modes alone
            end
         endcase
      end
   end
   // ---------------------------------------------------------------
   // trigger function expression tracking per function
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         prog <= 2'b00;
         has_edge <= 2'b00;
         has_or <= 2'b00;
         want_op <= 2'b00;
         edge_last <= 2'b00;
      end else if (accept) begin
         if (is_input(key_code_i)) begin
            prog[fs] <= 1'b1;
            want_op[fs] <= 1'b1;
            edge_last[fs] <= 1'b0;
         end else if (key_code_i == KEY_EDGE) begin
            has_edge[fs] <= 1'b1; // edge qualifies the last input
            edge_last[fs] <= 1'b1;
         end else if (key_code_i == KEY_AND) begin
            want_op[fs] <= 1'b0;
            edge_last[fs] <= 1'b0;
         end else if (key_code_i == KEY_OR) begin
            want_op[fs] <= 1'b0;
            has_or[fs] <= 1'b1;
            edge_last[fs] <= 1'b0;
         end else if (key_code_i == KEY_CLEAR) begin
            prog[fs] <= 1'b0;
            has_edge[fs] <= 1'b0;
            has_or[fs] <= 1'b0;
            want_op[fs] <= 1'b0;
            edge_last[fs] <= 1'b0;
         end
      end
   end
   // ---------------------------------------------------------------
   // probe offset: first press acquires, next locks, next turns off
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         probe <= PR_OFF;
      end else if (ce_i) begin
         case (probe)
            PR_OFF: if (accept && key_code_i == KEY_PROBE) probe <= PR_ACQ;
            PR_ACQ: begin
               // a press locks the value early; done also locks it
               if ((accept && key_code_i == KEY_PROBE) || probe_done_i) begin
                  probe <= PR_HELD;
               end
            end
            PR_HELD: if (accept && key_code_i == KEY_PROBE) probe <= PR_OFF;
            default: probe <= PR_OFF;
         endcase
      end
   end
   // ---------------------------------------------------------------
   // warning beep: fixed-length pulse, silenced by configuration
   // ---------------------------------------------------------------
   logic limit_evt;
   assign limit_evt = ce_i && key_valid_i && next_err == ERR_NONE &&
      ((scale_limit_i && (key_code_i == KEY_SCALE_UP || key_code_i == KEY_SCALE_DN)) ||
       (level_limit_i && (key_code_i == KEY_LEVEL_UP || key_code_i == KEY_LEVEL_DN)));
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         beep_cnt <= 16'h0000;
      end else if (ce_i) begin
         if (limit_evt && beep_en) begin
            beep_cnt <= 16'(BEEP_LEN);
         end else if (beep_cnt != 16'h0000) begin
            beep_cnt <= beep_cnt - 16'h0001;
         end
      end
   end
   // ---------------------------------------------------------------
   // wishbone slave: one wait state, unmapped reads zero
   // ---------------------------------------------------------------
   logic wb_req;
   assign wb_req = cyc_i && stb_i && !ack_o;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
      end else begin
         ack_o <= wb_req;
         dat_o <= 32'h0000_0000;
         if (wb_req && !we_i) begin
            case (adr_i)
               REG_STATUS: dat_o <= {16'h0000, 1'b0, probe, seq_on, threshold_entry_key_lit,
                  sync_on, trig_mode, chan_mode, sel_b, 2'b00, err};
               REG_IRQ_STAT: dat_o <= {29'h0000_0000, irq_stat};
               REG_IRQ_MASK: dat_o <= {29'h0000_0000, irq_mask};
               REG_CONFIG: dat_o <= {31'h0000_0000, beep_en};
               default: dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   // low byte written at the edge where the master sees ack high
   logic wr0;
   assign wr0 = cyc_i && stb_i && ack_o && we_i && sel_i[0];
   // configuration and mask registers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         beep_en <= CFG_BEEP_RESET;
         irq_mask <= IRQ_RESET;
      end else if (wr0) begin
         if (adr_i == REG_CONFIG) beep_en <= dat_i[0];
         if (adr_i == REG_IRQ_MASK) irq_mask <= dat_i[2:0];
      end
   end
   // sticky events: set wins over write-one-to-clear
   logic [2:0] evt;
   assign evt = {overload_i & ce_i & ~over_seen,
                 limit_evt,
                 ce_i & key_valid_i & (next_err != ERR_NONE)};
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat <= IRQ_RESET;
      end else begin
         irq_stat <= (irq_stat & ~((wr0 && adr_i == REG_IRQ_STAT) ? dat_i[2:0] : 3'h0))
                     | evt;
      end
   end
   // ---------------------------------------------------------------
   // registered outputs
   // ---------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         beep_o <= 1'b0;
      end else begin
         irq_o <= |(irq_stat & irq_mask);
         beep_o <= beep_cnt != 16'h0000;
      end
   end
   assign error_code_o = err;
   assign channel_programming_mode_o = chan_mode;
   assign trigger_programming_mode_o = trig_mode;
   assign external_sync_mode_o = sync_on;
   assign threshold_entry_key_o = threshold_entry_key_lit;
   assign sequential_mode_o = seq_on;
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   overload_shows_a: assert property (over_seen && ce_i |=> err == ERR_OVERLOAD)
      else $error("overload code not shown");
   probe_busy_a: assert property (ce_i && key_valid_i && !over_seen && probe == PR_ACQ &&
      key_code_i != KEY_PROBE |=> err == ERR_PROBE_BUSY && probe != PR_OFF)
      else $error("busy probe key not rejected");
   probe_off_a: assert property (accept && probe == PR_HELD && key_code_i == KEY_PROBE
      |=> probe == PR_OFF)
      else $error("probe not turned off");
   chan_mode_a: assert property (ce_i && key_valid_i && !over_seen && probe != PR_ACQ &&
      key_code_i == KEY_CH_GAIN && !chan_mode |=> err == ERR_NEED_CHAN)
      else $error("channel key outside mode accepted");
   trig_mode_a: assert property (ce_i && key_valid_i && !over_seen && probe != PR_ACQ &&
      key_code_i == KEY_OR && !trig_mode |=> err == ERR_NEED_TRIG && $stable(has_or))
      else $error("trigger key outside mode accepted");
   sync_slope_a: assert property (ce_i && key_valid_i && next_err == ERR_SYNC_REQUIRED
      |=> err == ERR_SYNC_REQUIRED && !sync_on)
      else $error("slope without sync accepted");
   reject_keeps_a: assert property (ce_i && key_valid_i && next_err != ERR_NONE
      |=> $stable(prog) && $stable(sync_on) && $stable(seq_on))
      else $error("rejected key changed state");
   beep_len_a: assert property (limit_evt && beep_en |=> ##1 beep_o [*3])
      else $error("beep too short");
   beep_mute_a: assert property (!beep_en && beep_cnt == 16'h0000 && !beep_o
      |=> ##1 !beep_o)
      else $error("muted beep sounded");
   seq_need_a: assert property (accept && key_code_i == KEY_A_THEN_B && !seq_on
      |-> prog == 2'b11)
      else $error("sequence started without both functions");
   cov_error_c: cover property (key_valid_i && ce_i ##1 err == ERR_SECOND_OR);
   cov_seq_c: cover property (accept && key_code_i == KEY_A_THEN_B);
   cov_beep_c: cover property (beep_o);
   cov_irq_c: cover property (irq_o);
endmodule
`default_nettype wire

// ===== bench/keypad_model.sv
/*
 keypad_model: the operator's front panel, one key press at a time.
 assumes: the checker samples a key on the edge where key_valid is high.
*/
`timescale 1ns/1ps
`default_nettype none
module keypad_model (
   // clock
   input wire logic clk_i,
   // key port towards the checker
   output logic key_valid_o,
   output logic [4:0] key_code_o
);
   // idle panel: no press, code lines carry junk
   initial begin
      key_valid_o = 1'b0;
      key_code_o = 5'h1F;
   end
   // ------------------------------------------------------------
   // one press: a single-cycle strobe, then the code is scrambled
   // ------------------------------------------------------------
   // the code is inverted after release so a checker that reads a stale
   // code outside the strobe shows up rather than passing by luck
   task automatic press(input logic [4:0] code);
      @(posedge clk_i);
      key_valid_o <= 1'b1;
      key_code_o <= code;
      @(posedge clk_i);
      key_valid_o <= 1'b0;
      key_code_o <= ~code;
   endtask
endmodule
`default_nettype wire

// ===== bench/trigger_keypad_error_checker_tb_top.sv
/*
 trigger_keypad_error_checker_tb_top: self-checking bench for the checker.
 assumes: keypad_model supplies presses; wishbone is driven here.
*/
`timescale 1ns/1ps
`default_nettype none
module trigger_keypad_error_checker_tb_top;
   import keypad_check_pkg::*;
   // ------------------------------------------------------------
   // clock, reset and stimulus signals
   // ------------------------------------------------------------
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic overload_i = 1'b0, grounded_i = 1'b0, scale_limit_i = 1'b0, level_limit_i = 1'b0;
   logic probe_done_i = 1'b0, ce_i = 1'b1;
   logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
   logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0000_0000, dat_o, rd;
   logic ack_o, key_valid, beep_o, irq_o;
   logic [4:0] key_code;
   logic [3:0] error_code_o;
   logic chan_m, trig_m, sync_m, thr_m, seq_m;
   int n_mismatch = 0, total_checks = 0, cycles = 0;
   always #2.5 clk_i = ~clk_i;
   // ------------------------------------------------------------
   // design and partner
   // ------------------------------------------------------------
   keypad_model kp (.clk_i(clk_i), .key_valid_o(key_valid), .key_code_o(key_code));
   trigger_keypad_error_checker #(.BEEP_LEN(4)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .key_valid_i(key_valid),
      .key_code_i(key_code), .overload_i(overload_i), .grounded_i(grounded_i),
      .scale_limit_i(scale_limit_i), .level_limit_i(level_limit_i),
      .probe_done_i(probe_done_i),
      .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
      .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .error_code_o(error_code_o),
      .channel_programming_mode_o(chan_m), .trigger_programming_mode_o(trig_m),
      .external_sync_mode_o(sync_m), .threshold_entry_key_o(thr_m),
      .sequential_mode_o(seq_m), .beep_o(beep_o), .irq_o(irq_o));
   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // classic single cycle; held until ack is sampled high, only the hang guard ends a wait
   task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d; sel_i <= 4'hF;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc_i <= 1'b0; stb_i <= 1'b0; we_i <= 1'b0;
      // the slave must let ack go in the cycle after it gave it
      @(posedge clk_i);
      chk("ack_drop", 0, ack_o);
   endtask
   // press a key and look at the error code one cycle later
   task automatic pk(input logic [4:0] code, input logic [3:0] exp);
      kp.press(code);
      @(posedge clk_i);
      #1 chk("error_code", {28'h0, exp}, {28'h0, error_code_o});
   endtask
   // press a key and count how long the beep stands
   task automatic beep_len(input logic [4:0] code, input int exp);
      int n;
      n = 0;
      kp.press(code);
      repeat (12) begin
         @(posedge clk_i);
         #1 if (beep_o === 1'b1) n++;
      end
      chk("beep_cycles", exp, n);
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_regs();
      wb(0, REG_CONFIG, 0);
      chk("config_reset", 32'h0000_0001, rd);
      wb(0, 4'h2, 0);
      chk("unmapped", 32'h0000_0000, rd);
   endtask
   task automatic t_modes();
      pk(KEY_OR, ERR_NEED_TRIG);
      chk("trig_mode", 0, trig_m);
      pk(KEY_TRIGGER_PROGRAMMING_MODE, ERR_NONE);
      chk("trig_mode", 1, trig_m);
      pk(KEY_CH_GAIN, ERR_NEED_CHAN);
      // a press while the enable is low must leave the shown code alone
      @(posedge clk_i);
      ce_i <= 1'b0;
      pk(KEY_AND, ERR_NEED_CHAN);
      @(posedge clk_i);
      ce_i <= 1'b1;
      pk(KEY_CHANNEL_PROGRAMMING_MODE, ERR_NONE);
      chk("chan_mode", 1, chan_m);
      chk("trig_mode", 0, trig_m);
      pk(KEY_CH_GAIN, ERR_NONE);
      pk(KEY_TRIGGER_PROGRAMMING_MODE, ERR_NONE);
   endtask
   task automatic t_expr();
      pk(KEY_CH1, ERR_NONE);
      pk(KEY_CH1, ERR_OP_EXPECTED);
      pk(KEY_NOT, ERR_OP_EXPECTED);
      pk(KEY_AND, ERR_NONE);
      pk(KEY_OR, ERR_INPUT_EXPECTED);
      pk(KEY_CH4, ERR_NONE);
      pk(KEY_OR, ERR_NONE);
      pk(KEY_CH1, ERR_NONE);
      pk(KEY_OR, ERR_SECOND_OR);
      pk(KEY_EDGE, ERR_NONE);
      pk(KEY_EDGE, ERR_OP_EXPECTED);
   endtask
   task automatic t_sync();
      pk(KEY_SLOPE, ERR_SYNC_REQUIRED);
      pk(KEY_SYNC, ERR_EDGE_CONFLICT);
      chk("sync_mode", 0, sync_m);
      pk(KEY_CLEAR, ERR_NONE);
      pk(KEY_SYNC, ERR_NONE);
      chk("sync_mode", 1, sync_m);
      pk(KEY_EDGE, ERR_SYNC_CONFLICT);
      pk(KEY_SLOPE, ERR_NONE);
   endtask
   task automatic t_seq();
      pk(KEY_CH1, ERR_NONE);
      pk(KEY_A_THEN_B, ERR_SECOND_FUNCTION_MISSING_ERROR);
      chk("seq_mode", 0, seq_m);
      pk(KEY_SEL_B, ERR_NONE);
      pk(KEY_CH4, ERR_NONE);
      pk(KEY_A_THEN_B, ERR_NONE);
      chk("seq_mode", 1, seq_m);
      pk(KEY_CLEAR, ERR_SECOND_FUNCTION_MISSING_ERROR);
      pk(KEY_SEL_A, ERR_NONE);
      pk(KEY_CLEAR, ERR_NO_FUNC_A);
      chk("seq_mode", 1, seq_m);
   endtask
   task automatic t_probe();
      pk(KEY_LEVEL_UP, ERR_LEVEL_REQUIRED);
      pk(KEY_PROBE, ERR_LEVEL_REQUIRED);
      pk(KEY_THRESHOLD_ENTRY_KEY, ERR_NONE);
      chk("threshold_entry_key_lit", 1, thr_m);
      pk(KEY_PROBE, ERR_NONE);
      wb(0, REG_STATUS, 0);
      chk("probe_acq", 3'b010, rd[14:12]);
      pk(KEY_CH1, ERR_PROBE_BUSY);
      pk(KEY_PROBE, ERR_NONE);
      wb(0, REG_STATUS, 0);
      chk("probe_held", 3'b100, rd[14:12]);
      pk(KEY_PROBE, ERR_NONE);
      wb(0, REG_STATUS, 0);
      chk("probe_off", 3'b001, rd[14:12]);
      // the analog side finishing also locks the value
      pk(KEY_PROBE, ERR_NONE);
      @(posedge clk_i);
      probe_done_i <= 1'b1;
      @(posedge clk_i);
      probe_done_i <= 1'b0;
      wb(0, REG_STATUS, 0);
      chk("probe_done", 3'b100, rd[14:12]);
      pk(KEY_PROBE, ERR_NONE);
   endtask
   task automatic t_beep();
      @(posedge clk_i);
      scale_limit_i <= 1'b1;
      level_limit_i <= 1'b1;
      beep_len(KEY_SCALE_UP, 4);
      beep_len(KEY_LEVEL_UP, 4);
      wb(1, REG_CONFIG, 32'h0000_0000);
      beep_len(KEY_SCALE_DN, 0);
      @(posedge clk_i);
      scale_limit_i <= 1'b0;
      level_limit_i <= 1'b0;
   endtask
   task automatic t_overload();
      overload_i <= 1'b1;
      grounded_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      overload_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk("overload_code", ERR_OVERLOAD, error_code_o);
      @(posedge clk_i);
      grounded_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      #1 chk("overload_gone", ERR_NONE, error_code_o);
   endtask
   task automatic t_irq();
      wb(0, REG_IRQ_STAT, 0);
      chk("irq_stat", 32'h0000_0007, rd);
      chk("irq_masked", 0, irq_o);
      wb(1, REG_IRQ_MASK, 32'h0000_0007);
      repeat (2) @(posedge clk_i);
      #1 chk("irq_on", 1, irq_o);
      wb(1, REG_IRQ_STAT, 32'h0000_0007);
      repeat (2) @(posedge clk_i);
      #1 chk("irq_off", 0, irq_o);
   endtask
   // ------------------------------------------------------------
   // main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      t_regs();
      t_modes();
      t_expr();
      t_sync();
      t_seq();
      t_probe();
      t_beep();
      t_overload();
      t_irq();
      give_verdict();
   end
   // the whole run needs well under a thousand cycles
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         n_mismatch++;
         give_verdict();
      end
   end
endmodule
`default_nettype wire
